/* File: verilog/rapf_defines.vh */
/*
  Constants for the radio packet framer: frame bytes, field ranges, defaults
  and delivery-mode encodings. Assumes inclusion by rapf_framer.v only.
*/
`ifndef RAPF_DEFINES_VH
`define RAPF_DEFINES_VH
`define RAPF_HDR_BYTE 8'h81
`define RAPF_DONE_HDR 8'h82
`define RAPF_MAX_LEN 8'h80
`define RAPF_BCAST_BYTE 8'hff
`define RAPF_CHAN_MIN 6'h10
`define RAPF_CHAN_MAX 6'h2f
`define RAPF_NETID_MAX 9'h100
`define RAPF_CNT_MIN 8'h02
`define RAPF_CNT_DEF 8'h04
`define RAPF_BUF_BYTES 9'h100
`define RAPF_FRAME_OVH 9'h007
`define RAPF_MODE_BCAST 2'h0
`define RAPF_MODE_AUTO 2'h1
`define RAPF_MODE_ADDR 2'h2
`define RAPF_ADDR_BYTES 3'h3
`define RAPF_TX_HDR_BYTES 4'h7
`define RAPF_RX_HDR_BYTES 4'h7
`define RAPF_LFSR_SEED 16'hace1
`define RAPF_MAC_RESET 48'h0000_0000_0000
`endif

/* File: verilog/rapf_framer.v */
/*
  Radio packet framer: host byte stream in, radio packet requests out,
  radio events in, framed host bytes out. One clock; controls are ports except the LOCAL_MAC and BACKOFF_UNIT parameters.
  Assumes the radio front end handles modulation, cipher and collision sense,
  and that the host byte stream is already deserialised on ref_clk.
*/
// What this block does
// - send done report on ack or exhaustion
// - success bit on received ack, or after broadcast repeats
// - broadcast always reports success after repeats
// - remote-heard strength first, then local-heard
// - framed receive: 81h,len,strengths,addr 2,1,0,payload
// - three framing options enable independently
// - pending done report goes before framed receive
// - framed host addressing overrides delivery mode
// - channel accepted only in 16..47
// - point-to-point retries capped, then discard
// - broadcast sends exactly configured attempts
// - match both channel and network identifier
// - 56-bit key enable passed to radio
// - fixed unique 6-byte hardware address
// - broadcast mode addresses all units
// - auto mode latches first sender address
// - addressed mode only talks to destination while framed host interface is off
// - parity option selects 9-bit host characters
// - ignore-broadcast drops received broadcasts
// - random backoff after collision, spread configurable
// - modem lines only when not rs-485
// - full-duplex option forwarded to radio
// - framing bytes neither stored in nor counted against 256-byte buffer
// - all-ffh framed destination sends broadcast
// - malformed header sends string as raw
`timescale 1ns/100ps
`include "rapf_defines.vh"
module rapf_framer #(
  parameter [47:0] LOCAL_MAC = 48'h02_00_00_00_00_01, // arbitrary value
  parameter [7:0] BACKOFF_UNIT = 8'h10
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [5:0] channel_number,
  input wire [8:0] network_identifier,
  input wire [1:0] delivery_mode,
  input wire [23:0] dest_addr_cfg,
  input wire [7:0] retry_limit,
  input wire [7:0] bcast_attempts,
  input wire [7:0] backoff_spread,
  input wire framed_host_interface,
  input wire tx_framed_input,
  input wire done_report_en,
  input wire rx_framed_delivery,
  input wire ignore_bcast,
  input wire encrypt_en,
  input wire parity_en,
  input wire full_duplex_en,
  input wire modem_mode_en,
  input wire rs485_sel,
  input wire host_in_valid,
  input wire [7:0] host_in_data,
  input wire host_out_ready,
  input wire rf_tx_busy,
  input wire rf_ack,
  input wire rf_collision,
  input wire [7:0] rf_ack_strength_remote,
  input wire [7:0] rf_ack_strength_local,
  input wire rf_rx_valid,
  input wire rf_rx_first,
  input wire [7:0] rf_rx_data,
  input wire [5:0] rf_rx_channel,
  input wire [8:0] rf_rx_netid,
  input wire [23:0] rf_rx_src,
  input wire [23:0] rf_rx_dst,
  input wire [7:0] rf_rx_len,
  input wire [7:0] rf_rx_str_remote,
  input wire [7:0] rf_rx_str_local,
  output reg host_in_ready,
  output reg host_out_valid,
  output reg [7:0] host_out_data,
  output reg rf_tx_start,
  output reg [23:0] rf_tx_dst,
  output reg rf_tx_bcast,
  output reg [7:0] rf_tx_len,
  output reg [7:0] rf_tx_pay_addr,
  output reg channel_ok,
  output reg [47:0] local_mac,
  output reg encrypt_on,
  output reg host_nine_bit,
  output reg full_duplex_on,
  output reg modem_lines_on
);
  localparam [4:0] TS_IDLE = 5'h01;
  localparam [4:0] TS_BACKOFF = 5'h02;
  localparam [4:0] TS_SEND = 5'h04;
  localparam [4:0] TS_WAIT = 5'h08;
  localparam [4:0] TS_DONE = 5'h10;

  // transmit payload store; framing bytes are neither kept nor counted in it
  reg [7:0] pay_mem [0:255];
  reg [7:0] rx_mem [0:255];
  reg [3:0] hcnt_reg;
  reg [7:0] plen_reg;
  reg [7:0] pcnt_reg;
  reg [7:0] fcount_reg;
  reg [23:0] fdst_reg;
  reg raw_reg;
  reg pkt_ready_reg;
  reg pkt_raw_reg;
  reg [4:0] ts_reg;
  reg [7:0] tries_reg;
  reg [7:0] limit_reg;
  reg bcast_reg;
  reg [23:0] dst_reg;
  reg [15:0] lfsr_reg;
  reg [15:0] bo_reg;
  reg success_reg;
  reg [7:0] str_r_reg;
  reg [7:0] str_l_reg;
  reg done_pend_reg;
  reg [2:0] dcnt_reg;
  reg auto_set_reg;
  reg [23:0] auto_dst_reg;
  reg rx_keep_reg;
  reg rx_pend_reg;
  reg [7:0] rx_len_reg;
  reg [7:0] rx_wr_reg;
  reg [7:0] rx_sr_reg;
  reg [7:0] rx_sl_reg;
  reg [23:0] rx_src_reg;
  reg [8:0] rx_ocnt_reg;

  wire host_take = host_in_valid & host_in_ready;
  wire framed_tx = framed_host_interface & tx_framed_input;
  wire [23:0] mode_dst = (delivery_mode == `RAPF_MODE_AUTO) ? auto_dst_reg : dest_addr_cfg;
  wire mode_bcast = (delivery_mode == `RAPF_MODE_BCAST);
  wire rx_net_ok = (rf_rx_channel == channel_number) & (rf_rx_netid == network_identifier);
  wire rx_is_bcast = (rf_rx_dst == {3{`RAPF_BCAST_BYTE}});
  wire rx_peer_ok = framed_host_interface | (delivery_mode != `RAPF_MODE_ADDR) |
                    (rf_rx_src == dest_addr_cfg);
  wire rx_mine = rx_is_bcast | (rf_rx_dst == local_mac[23:0]);
  wire rx_accept = rx_net_ok & rx_mine & rx_peer_ok & ~(ignore_bcast & rx_is_bcast);
  // receive framing needs both framed_host_interface and rx_framed_delivery
  wire rx_hdr_on = framed_host_interface & rx_framed_delivery;
  // unframed delivery skips the seven header positions
  wire [8:0] rx_idx = (rx_hdr_on || rx_ocnt_reg >= {5'h00, `RAPF_RX_HDR_BYTES}) ? rx_ocnt_reg :
                      {5'h00, `RAPF_RX_HDR_BYTES};

  // host byte intake and framed header parsing
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hcnt_reg <= 4'h0;
      plen_reg <= 8'h00;
      pcnt_reg <= 8'h00;
      fcount_reg <= 8'h00;
      fdst_reg <= 24'h000000;
      raw_reg <= 1'b0;
      pkt_ready_reg <= 1'b0;
      pkt_raw_reg <= 1'b0;
      host_in_ready <= 1'b0;
    end else begin
      // stall intake while a packet is held
      host_in_ready <= ~pkt_ready_reg & ~host_take;
      // frame and its header fields stay held until the send has ended
      if (ts_reg[4])
        pkt_ready_reg <= 1'b0;
      if (host_take) begin
        if (!framed_tx || raw_reg) begin
          // raw string up to 80h bytes
          pay_mem[pcnt_reg] <= host_in_data;
          pcnt_reg <= pcnt_reg + 8'h01;
          if (pcnt_reg + 8'h01 == `RAPF_MAX_LEN) begin
            plen_reg <= `RAPF_MAX_LEN;
            pkt_ready_reg <= 1'b1;
            pkt_raw_reg <= 1'b1;
            raw_reg <= 1'b0;
            pcnt_reg <= 8'h00;
          end
        end else if (hcnt_reg == 4'h0) begin
          if (host_in_data == `RAPF_HDR_BYTE)
            hcnt_reg <= 4'h1;
          else begin
            raw_reg <= 1'b1;
            pay_mem[8'h00] <= host_in_data;
            pcnt_reg <= 8'h01;
          end
        end else if (hcnt_reg == 4'h1) begin
          if (host_in_data == 8'h00 || host_in_data > `RAPF_MAX_LEN) begin
            raw_reg <= 1'b1;
            hcnt_reg <= 4'h0;
            pay_mem[8'h00] <= `RAPF_HDR_BYTE;
            pay_mem[8'h01] <= host_in_data;
            pcnt_reg <= 8'h02;
          end else begin
            plen_reg <= host_in_data;
            hcnt_reg <= 4'h2;
          end
        end else if (hcnt_reg == 4'h2) begin
          hcnt_reg <= 4'h3;
        end else if (hcnt_reg == 4'h3) begin
          fcount_reg <= host_in_data;
          hcnt_reg <= 4'h4;
        end else if (hcnt_reg < `RAPF_TX_HDR_BYTES) begin
          fdst_reg <= {fdst_reg[15:0], host_in_data};
          hcnt_reg <= hcnt_reg + 4'h1;
        end else begin
          pay_mem[pcnt_reg] <= host_in_data;
          pcnt_reg <= pcnt_reg + 8'h01;
          if (pcnt_reg + 8'h01 == plen_reg) begin
            pkt_ready_reg <= 1'b1;
            pkt_raw_reg <= 1'b0;
            hcnt_reg <= 4'h0;
            pcnt_reg <= 8'h00;
          end
        end
      end
    end
  end

  // transmit attempts, retries and backoff
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ts_reg <= TS_IDLE;
      tries_reg <= 8'h00;
      limit_reg <= `RAPF_CNT_DEF;
      bcast_reg <= 1'b0;
      dst_reg <= 24'h000000;
      lfsr_reg <= `RAPF_LFSR_SEED;
      bo_reg <= 16'h0000;
      success_reg <= 1'b0;
      str_r_reg <= 8'h00;
      str_l_reg <= 8'h00;
      done_pend_reg <= 1'b0;
      rf_tx_start <= 1'b0;
      rf_tx_dst <= 24'h000000;
      rf_tx_bcast <= 1'b0;
      rf_tx_len <= 8'h00;
      rf_tx_pay_addr <= 8'h00;
    end else begin
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
      rf_tx_start <= 1'b0;
      if (dcnt_reg == `RAPF_TX_HDR_BYTES - 4'h1 && host_out_ready && host_out_valid)
        done_pend_reg <= 1'b0;
      case (ts_reg)
        TS_IDLE: begin
          if (pkt_ready_reg && channel_ok) begin
            tries_reg <= 8'h00;
            success_reg <= 1'b0;
            if (framed_tx && !pkt_raw_reg) begin
              bcast_reg <= (fdst_reg == {3{`RAPF_BCAST_BYTE}});
              dst_reg <= fdst_reg;
              limit_reg <= (fcount_reg < `RAPF_CNT_MIN) ? `RAPF_CNT_MIN : fcount_reg;
            end else begin
              bcast_reg <= mode_bcast;
              dst_reg <= mode_bcast ? {3{`RAPF_BCAST_BYTE}} : mode_dst;
              limit_reg <= mode_bcast ? bcast_attempts : retry_limit;
            end
            ts_reg <= TS_SEND;
          end
        end
        TS_BACKOFF: begin
          if (bo_reg == 16'h0000)
            ts_reg <= TS_SEND;
          else
            bo_reg <= bo_reg - 16'h0001;
        end
        TS_SEND: begin
          if (!rf_tx_busy) begin
            rf_tx_start <= 1'b1;
            rf_tx_dst <= dst_reg;
            rf_tx_bcast <= bcast_reg;
            rf_tx_len <= plen_reg;
            rf_tx_pay_addr <= 8'h00;
            tries_reg <= tries_reg + 8'h01;
            ts_reg <= TS_WAIT;
          end
        end
        TS_WAIT: begin
          if (rf_collision) begin
            bo_reg <= BACKOFF_UNIT * (lfsr_reg[7:0] & backoff_spread);
            tries_reg <= tries_reg - 8'h01;
            ts_reg <= TS_BACKOFF;
          end else if (rf_ack && !bcast_reg) begin
            success_reg <= 1'b1;
            str_r_reg <= rf_ack_strength_remote;
            str_l_reg <= rf_ack_strength_local;
            ts_reg <= TS_DONE;
          end else if (!rf_tx_busy && !rf_tx_start) begin
            if (tries_reg >= limit_reg) begin
              success_reg <= bcast_reg;
              ts_reg <= TS_DONE;
            end else
              ts_reg <= TS_SEND;
          end
        end
        TS_DONE: begin
          if (done_report_en && framed_host_interface)
            done_pend_reg <= 1'b1;
          ts_reg <= TS_IDLE;
        end
        default: ts_reg <= TS_IDLE;
      endcase
    end
  end

  // receive capture and host output with report priority
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_set_reg <= 1'b0;
      auto_dst_reg <= 24'h000000;
      rx_keep_reg <= 1'b0;
      rx_pend_reg <= 1'b0;
      rx_len_reg <= 8'h00;
      rx_wr_reg <= 8'h00;
      rx_sr_reg <= 8'h00;
      rx_sl_reg <= 8'h00;
      rx_src_reg <= 24'h000000;
      rx_ocnt_reg <= 9'h000;
      dcnt_reg <= 3'h0;
      host_out_valid <= 1'b0;
      host_out_data <= 8'h00;
    end else begin
      if (rf_rx_valid && rf_rx_first) begin
        rx_keep_reg <= rx_accept & ~rx_pend_reg;
        if (rx_accept && !rx_pend_reg) begin
          rx_len_reg <= rf_rx_len;
          rx_sr_reg <= rf_rx_str_remote;
          rx_sl_reg <= rf_rx_str_local;
          rx_src_reg <= rf_rx_src;
          rx_mem[8'h00] <= rf_rx_data;
          rx_wr_reg <= 8'h01;
          rx_pend_reg <= (rf_rx_len == 8'h01);
          if (!auto_set_reg && delivery_mode == `RAPF_MODE_AUTO) begin
            auto_set_reg <= 1'b1;
            auto_dst_reg <= rf_rx_src;
          end
        end
      end else if (rf_rx_valid && rx_keep_reg && !rx_pend_reg) begin
        rx_mem[rx_wr_reg] <= rf_rx_data;
        rx_wr_reg <= rx_wr_reg + 8'h01;
        if (rx_wr_reg + 8'h01 == rx_len_reg)
          rx_pend_reg <= 1'b1;
      end
      if (host_out_valid && !host_out_ready) begin
        host_out_valid <= 1'b1;
      end else if (done_pend_reg && rx_ocnt_reg == 9'h000) begin
        host_out_valid <= 1'b1;
        case (dcnt_reg)
          3'h0: host_out_data <= `RAPF_DONE_HDR;
          3'h1: host_out_data <= str_r_reg;
          3'h2: host_out_data <= str_l_reg;
          3'h3: host_out_data <= dst_reg[23:16];
          3'h4: host_out_data <= dst_reg[15:8];
          3'h5: host_out_data <= dst_reg[7:0];
          default: host_out_data <= {7'h00, success_reg};
        endcase
        dcnt_reg <= (dcnt_reg == `RAPF_TX_HDR_BYTES - 4'h1) ? 3'h0 : dcnt_reg + 3'h1;
      end else if (rx_pend_reg) begin
        host_out_valid <= 1'b1;
        case (rx_idx)
          9'h000: host_out_data <= `RAPF_HDR_BYTE;
          9'h001: host_out_data <= rx_len_reg;
          9'h002: host_out_data <= rx_sr_reg;
          9'h003: host_out_data <= rx_sl_reg;
          9'h004: host_out_data <= rx_src_reg[23:16];
          9'h005: host_out_data <= rx_src_reg[15:8];
          9'h006: host_out_data <= rx_src_reg[7:0];
          default: host_out_data <= rx_mem[rx_idx[7:0] - {4'h0, `RAPF_RX_HDR_BYTES}];
        endcase
        rx_ocnt_reg <= rx_idx + 9'h001;
        if (rx_idx + 9'h001 >= {1'b0, rx_len_reg} + {5'h00, `RAPF_RX_HDR_BYTES}) begin
          rx_pend_reg <= 1'b0;
          rx_ocnt_reg <= 9'h000;
        end
      end else
        host_out_valid <= 1'b0;
    end
  end

  // static option outputs
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_ok <= 1'b0;
      local_mac <= `RAPF_MAC_RESET;
      encrypt_on <= 1'b0;
      host_nine_bit <= 1'b0;
      full_duplex_on <= 1'b0;
      modem_lines_on <= 1'b0;
    end else begin
      // channel 16..47 and netid up to 256
      channel_ok <= (channel_number >= `RAPF_CHAN_MIN) & (channel_number <= `RAPF_CHAN_MAX) &
                    (network_identifier <= `RAPF_NETID_MAX);
      local_mac <= LOCAL_MAC;
      encrypt_on <= encrypt_en;
      host_nine_bit <= parity_en;
      full_duplex_on <= full_duplex_en;
      modem_lines_on <= modem_mode_en & ~rs485_sel;
    end
  end
endmodule

/* File: test/rapf_chk.sv */
/*
  Port checker for the radio packet framer.
  Assumes configuration levels held steady and one-cycle registered status outputs.
*/
`timescale 1ns/100ps
module rapf_chk #(
  parameter [47:0] LOCAL_MAC = 48'h0
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [5:0] channel_number,
  input wire encrypt_en,
  input wire parity_en,
  input wire modem_mode_en,
  input wire rs485_sel,
  input wire host_out_ready,
  input wire host_out_valid,
  input wire [7:0] host_out_data,
  input wire rf_tx_start,
  input wire [23:0] rf_tx_dst,
  input wire rf_tx_bcast,
  input wire [7:0] rf_tx_len,
  input wire channel_ok,
  input wire [47:0] local_mac,
  input wire encrypt_on,
  input wire host_nine_bit,
  input wire modem_lines_on
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_chan_range: assert property ($past(rst_n) && $stable(channel_number) |=>
    channel_ok == ($past(channel_number) inside {[6'h10:6'h2f]})) else $error("channel_ok wrong");
  a_encrypt_follow: assert property (rst_n |=> encrypt_on == $past(encrypt_en))
    else $error("encrypt_on wrong");
  a_nine_bit: assert property (rst_n |=> host_nine_bit == $past(parity_en))
    else $error("host_nine_bit wrong");
  a_modem_excl: assert property (rst_n |=>
    modem_lines_on == $past(modem_mode_en && !rs485_sel)) else $error("modem lines wrong");
  a_mac_fixed: assert property (rst_n |=> local_mac == LOCAL_MAC)
    else $error("local_mac wrong");
  a_start_pulse: assert property (rf_tx_start |=> !rf_tx_start)
    else $error("start longer than one cycle");
  a_out_hold: assert property (host_out_valid && !host_out_ready |=>
    host_out_valid && $stable(host_out_data)) else $error("host byte dropped in stall");
  a_bcast_flag: assert property (rf_tx_start && rf_tx_dst == 24'hffffff |-> rf_tx_bcast)
    else $error("all-ones destination not broadcast");
  a_len_bound: assert property (rf_tx_start |-> rf_tx_len inside {[8'h01:8'h80]})
    else $error("send length out of range");
  c_bcast: cover property (rf_tx_start && rf_tx_bcast);
  c_unicast: cover property (rf_tx_start && !rf_tx_bcast);
  c_stall: cover property (host_out_valid && !host_out_ready);
endmodule
bind rapf_framer rapf_chk #(.LOCAL_MAC(LOCAL_MAC)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .channel_number(channel_number),
  .encrypt_en(encrypt_en), .parity_en(parity_en), .modem_mode_en(modem_mode_en),
  .rs485_sel(rs485_sel), .host_out_ready(host_out_ready), .host_out_valid(host_out_valid),
  .host_out_data(host_out_data), .rf_tx_start(rf_tx_start), .rf_tx_dst(rf_tx_dst),
  .rf_tx_bcast(rf_tx_bcast), .rf_tx_len(rf_tx_len), .channel_ok(channel_ok),
  .local_mac(local_mac), .encrypt_on(encrypt_on), .host_nine_bit(host_nine_bit),
  .modem_lines_on(modem_lines_on));

/* File: test/rapf_host_model.sv */
/*
  Host partner: puts bytes on the framer's input stream, collects its output.
  Assumes the framer's clock; slow makes the sink stall every other cycle.
*/
`timescale 1ns/100ps
module rapf_host_model (
  input wire ref_clk,
  input wire slow,
  input wire host_in_ready,
  output reg host_in_valid,
  output reg [7:0] host_in_data,
  input wire host_out_valid,
  input wire [7:0] host_out_data,
  output reg host_out_ready
);
  logic [7:0] outq[$];
  integer stalls = 0;
  initial begin
    host_in_valid = 1'b0;
    host_in_data = 8'h00;
    host_out_ready = 1'b0;
  end
  task put(input [7:0] b);
    integer n;
    begin
      n = 0;
      @(posedge ref_clk);
      host_in_valid <= 1'b1;
      host_in_data <= b;
      do begin
        @(posedge ref_clk);
        n = n + 1;
      end while (host_in_ready !== 1'b1 && n < 100);
      if (n == 100) stalls = stalls + 1;
      host_in_valid <= 1'b0;
      // released data must not repeat the last byte
      host_in_data <= ~b;
    end
  endtask
  always @(posedge ref_clk) begin
    if (host_out_valid && host_out_ready) outq.push_back(host_out_data);
    host_out_ready <= slow ? ~host_out_ready : 1'b1;
  end
endmodule

/* File: test/rapf_framer_tb.sv */
/*
  Self-checking bench for the radio packet framer: host partner plus a small
  radio front end here. Assumes the framer's single 125 MHz clock.
*/
`timescale 1ns/100ps
module rapf_framer_tb;
  localparam [47:0] MAC = 48'h02_00_00_00_00_5a; // arbitrary value
  reg ref_clk = 1'b0;
  reg rst_n = 1'b0;
  reg [5:0] chan = 6'h10;
  reg [8:0] nid = 9'h100;
  reg [9:0] opt = 10'h3de;
  reg [7:0] retries = 8'h04;
  reg [15:0] str = 16'h4142;
  reg [39:0] rxm = 40'h3c4d5e6162;
  reg [7:0] rx_len = 8'h02;
  reg [8:0] rx_nid = 9'h100;
  reg [23:0] rx_dst = MAC[23:0];
  reg slow = 1'b1;
  reg ack_on = 1'b0;
  reg rf_tx_busy = 1'b0;
  reg rf_ack = 1'b0;
  reg rf_rx_valid = 1'b0;
  reg rf_rx_first = 1'b0;
  reg [7:0] rf_rx_data = 8'h00;
  reg [2:0] bcnt = 3'h0;
  reg [23:0] last_dst = 24'h0;
  reg last_bc = 1'b0;
  reg [7:0] last_len = 8'h00;
  integer starts = 0;
  integer miscompares = 0;
  integer checks_done = 0;
  wire h_iv, h_or, host_in_ready, host_out_valid, rf_tx_start, rf_tx_bcast, channel_ok;
  wire modem_lines_on;
  wire [7:0] h_id, host_out_data, rf_tx_len;
  wire [23:0] rf_tx_dst;
  wire [47:0] local_mac;
  rapf_framer #(.LOCAL_MAC(MAC), .BACKOFF_UNIT(8'h02)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .channel_number(chan), .network_identifier(nid),
    .delivery_mode(2'h2), .dest_addr_cfg(24'h777777), .retry_limit(retries),
    .bcast_attempts(retries), .backoff_spread(8'h03), .framed_host_interface(opt[9]),
    .tx_framed_input(opt[8]), .done_report_en(opt[7]), .rx_framed_delivery(opt[6]),
    .ignore_bcast(opt[5]), .encrypt_en(opt[4]), .parity_en(opt[3]),
    .full_duplex_en(opt[2]), .modem_mode_en(opt[1]), .rs485_sel(opt[0]),
    .host_in_valid(h_iv), .host_in_data(h_id), .host_out_ready(h_or),
    .rf_tx_busy(rf_tx_busy), .rf_ack(rf_ack), .rf_collision(1'b0),
    .rf_ack_strength_remote(str[15:8]), .rf_ack_strength_local(str[7:0]),
    .rf_rx_valid(rf_rx_valid), .rf_rx_first(rf_rx_first), .rf_rx_data(rf_rx_data),
    .rf_rx_channel(chan), .rf_rx_netid(rx_nid), .rf_rx_src(rxm[39:16]),
    .rf_rx_dst(rx_dst), .rf_rx_len(rx_len), .rf_rx_str_remote(rxm[15:8]),
    .rf_rx_str_local(rxm[7:0]), .host_in_ready(host_in_ready),
    .host_out_valid(host_out_valid), .host_out_data(host_out_data),
    .rf_tx_start(rf_tx_start), .rf_tx_dst(rf_tx_dst), .rf_tx_bcast(rf_tx_bcast),
    .rf_tx_len(rf_tx_len), .rf_tx_pay_addr(), .channel_ok(channel_ok),
    .local_mac(local_mac), .encrypt_on(), .host_nine_bit(), .full_duplex_on(),
    .modem_lines_on(modem_lines_on));
  rapf_host_model host (.ref_clk(ref_clk), .slow(slow), .host_in_ready(host_in_ready),
    .host_in_valid(h_iv), .host_in_data(h_id), .host_out_valid(host_out_valid),
    .host_out_data(host_out_data), .host_out_ready(h_or));
  always #4 ref_clk = ~ref_clk;
  // radio: busy five cycles per attempt, ack mid-attempt when enabled
  always @(posedge ref_clk) begin
    rf_ack <= 1'b0;
    if (rf_tx_start) begin
      starts <= starts + 1;
      last_dst <= rf_tx_dst;
      last_bc <= rf_tx_bcast;
      last_len <= rf_tx_len;
      bcnt <= 3'h5;
      rf_tx_busy <= 1'b1;
    end else if (bcnt != 3'h0) begin
      bcnt <= bcnt - 3'h1;
      rf_ack <= ack_on && bcnt == 3'h3;
      rf_tx_busy <= bcnt != 3'h1;
    end
  end
  task chk(input string name, input [47:0] seen, input [47:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task end_of_test;
    begin
      miscompares = miscompares + host.stalls;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task get(output [7:0] b);
    integer n;
    begin
      n = 0;
      while (host.outq.size() == 0 && n < 400) begin
        @(posedge ref_clk);
        n = n + 1;
      end
      if (n == 400) begin
        miscompares = miscompares + 1;
        $display("MISMATCH host_out expected byte seen timeout");
        end_of_test;
      end else b = host.outq.pop_front();
    end
  endtask
  task tx_pkt(input [7:0] cnt, input [23:0] dst);
    reg [71:0] fr;
    integer i;
    begin
      fr = {8'h81, 8'h02, 8'h00, cnt, dst, 8'haa, 8'hbb};
      for (i = 0; i < 9; i = i + 1) host.put(fr[71 - 8 * i -: 8]);
    end
  endtask
  task report(input [23:0] dst, input ok, input [7:0] attempts, input integer s0);
    reg [7:0] b;
    integer i;
    begin
      get(b);
      chk("done_hdr", b, 8'h82);
      get(b);
      if (ack_on) chk("remote_str", b, str[15:8]);
      get(b);
      if (ack_on) chk("local_str", b, str[7:0]);
      for (i = 0; i < 3; i = i + 1) begin
        get(b);
        chk("done_dst", b, dst[23 - 8 * i -: 8]);
      end
      get(b);
      chk("done_ok", b[0], ok);
      chk("attempts", 48'(starts - s0), attempts);
      chk("tx_dst", last_dst, dst);
      chk("tx_len", last_len, 8'h02);
    end
  endtask
  task rx_pkt(input [8:0] id);
    integer i;
    begin
      for (i = 0; i < 2; i = i + 1) begin
        @(posedge ref_clk);
        rf_rx_valid <= 1'b1;
        rf_rx_first <= i == 0;
        rf_rx_data <= 8'hd0 + 8'(i);
        rx_nid <= id;
      end
      @(posedge ref_clk);
      rf_rx_valid <= 1'b0;
      repeat (10) @(posedge ref_clk);
    end
  endtask
  task rx_expect;
    reg [71:0] fr;
    reg [7:0] b;
    integer i;
    begin
      fr = {8'h81, rx_len, rxm[15:0], rxm[39:16], 8'hd0, 8'hd1};
      for (i = 0; i < 9; i = i + 1) begin
        get(b);
        chk("rx_byte", b, fr[71 - 8 * i -: 8]);
      end
    end
  endtask
  task t_cfg;
    reg [23:0] v;
    integer i;
    begin
      v = {6'h0f, 6'h10, 6'h2f, 6'h30};
      for (i = 0; i < 4; i = i + 1) begin
        @(posedge ref_clk);
        chan <= v[23 - 6 * i -: 6];
        repeat (3) @(posedge ref_clk);
        chk("channel_ok", channel_ok, i == 1 || i == 2);
      end
      chan <= 6'h10;
      opt[0] <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk("modem_lines", modem_lines_on, 1'b0);
      chk("local_mac", local_mac, MAC);
      opt[0] <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk("modem_lines", modem_lines_on, 1'b1);
      $display("test cfg done");
    end
  endtask
  task t_ack;
    integer s0;
    begin
      slow <= 1'b0;
      ack_on <= 1'b1;
      s0 = starts;
      tx_pkt(8'h03, 24'h123456);
      report(24'h123456, 1'b1, 8'h01, s0);
      slow <= 1'b1;
      $display("test ack done");
    end
  endtask
  task t_retry;
    integer s0;
    begin
      ack_on <= 1'b0;
      s0 = starts;
      tx_pkt(8'h03, 24'h123456);
      report(24'h123456, 1'b0, 8'h03, s0);
      $display("test retry done");
    end
  endtask
  task t_bcast;
    integer s0;
    begin
      s0 = starts;
      tx_pkt(8'h02, 24'hffffff);
      report(24'hffffff, 1'b1, 8'h02, s0);
      chk("tx_bcast", last_bc, 1'b1);
      $display("test bcast done");
    end
  endtask
  task t_rx;
    reg [7:0] b;
    integer i;
    begin
      rx_pkt(9'h0ff);
      chk("netid_drop", host.outq.size(), 0);
      opt[5] <= 1'b1;
      rx_dst <= 24'hffffff;
      rx_pkt(nid);
      chk("bcast_drop", host.outq.size(), 0);
      opt[5] <= 1'b0;
      rx_dst <= MAC[23:0];
      rx_pkt(nid);
      rx_expect;
      opt[6] <= 1'b0;
      rx_pkt(nid);
      for (i = 0; i < 2; i = i + 1) begin
        get(b);
        chk("rx_unframed", b, 8'hd0 + 8'(i));
      end
      opt[6] <= 1'b1;
      repeat (60) @(posedge ref_clk);
      chk("rx_extra", host.outq.size(), 0);
      $display("test rx done");
    end
  endtask
  task t_order;
    integer s0;
    integer n;
    begin
      ack_on <= 1'b1;
      s0 = starts;
      tx_pkt(8'h02, 24'h0a0b0c);
      n = 0;
      while (rf_ack !== 1'b1 && n < 200) begin
        @(posedge ref_clk);
        n = n + 1;
      end
      if (n == 200) begin
        miscompares = miscompares + 1;
        $display("MISMATCH rf_ack expected pulse seen timeout");
        end_of_test;
      end
      rx_pkt(nid);
      report(24'h0a0b0c, 1'b1, 8'h01, s0);
      rx_expect;
      $display("test order done");
    end
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_cfg;
    t_ack;
    t_retry;
    t_bcast;
    t_rx;
    t_order;
    end_of_test;
  end
endmodule
